// ---- pkg/flash_seq_pkg.sv ----
// Constants, types and command codes for the flash command sequencer.
// Assumes a 250 MHz core clock and a serial link clocked by the host.
package flash_seq_pkg;
  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned clock_mhz            = 250;
  localparam int unsigned prog_latency_us      = 7;
  localparam int unsigned erase_latency_us     = 15;
  localparam int unsigned prog_latency_cycles  = prog_latency_us * clock_mhz;
  localparam int unsigned erase_latency_cycles = erase_latency_us * clock_mhz;
  localparam int unsigned full_array_erase_time_us = 1000;
  localparam int unsigned sector_erase_time_us     = 400;
  localparam int unsigned program_time_us          = 100;
  localparam int unsigned full_array_erase_cycles_dflt = full_array_erase_time_us * clock_mhz;
  localparam int unsigned sector_erase_cycles_dflt     = sector_erase_time_us * clock_mhz;
  localparam int unsigned program_cycles_dflt          = program_time_us * clock_mhz;
  // ****************************************
  // Flag status layout
  // ****************************************
  localparam int unsigned fsr_ready      = 7;
  localparam int unsigned fsr_erase_susp = 6;
  localparam int unsigned fsr_erase_err  = 5;
  localparam int unsigned fsr_prog_err   = 4;
  localparam int unsigned fsr_prog_susp  = 2;
  localparam int unsigned fsr_protect    = 1;
  localparam logic [7:0]  fsr_reset      = 8'h80;
  // ****************************************
  // Frame geometry
  // ****************************************
  localparam int unsigned byte_bits     = 8;
  localparam int unsigned addr_end_bits = 32;
  localparam int unsigned prog_min_bits = 40;
  localparam int unsigned page_lsb      = 8;
  localparam int unsigned sector_lsb    = 16;
  // ****************************************
  // Command codes
  // ****************************************
  localparam logic [7:0] op_write_enable_dflt  = 8'h06;
  localparam logic [7:0] op_write_disable_dflt = 8'h04;
  localparam int unsigned op_count = 18;
  // Order: wren wrdi clear_flags lock_wr vcfg_wr evcfg_wr status_wr nvcfg_wr
  // otp_prog full_erase sector_erase subsector_erase program read
  // status_rd flag_rd suspend resume. Codes past the first two are arbitrary.
  localparam logic [8*op_count-1:0] op_table_dflt = {
    8'h06, 8'h04, 8'h50, 8'he5, 8'h81, 8'h61, 8'h01, 8'hb1, 8'h42,
    8'hc7, 8'hd8, 8'h20, 8'h02, 8'h03, 8'h05, 8'h70, 8'h75, 8'h7a};
  typedef logic [11:0] bitcnt_t;
  typedef logic [31:0] timer_t;
  typedef enum logic [3:0] {
    c_status_read, c_read, c_program, c_sector_erase, c_full_erase,
    c_guarded_write, c_free_write, c_suspend, c_resume, c_unknown
  } cls_t;
  typedef enum logic [2:0] {
    st_standby = 3'b000, st_erase = 3'b001, st_esusp = 3'b011,
    st_prog_es = 3'b010, st_nested = 3'b110, st_prog = 3'b100,
    st_psusp = 3'b101
  } state_t;
  typedef struct packed {
    logic        done;
    logic        accepted;
    logic        undefined_read;
    logic [7:0]  opcode;
    logic [23:0] addr;
  } report_t;
endpackage : flash_seq_pkg

// ---- src/flash_cmd_seq.sv ----
// Command sequencer for a serial NOR flash: erase, program, suspend, resume.
// Assumes the host holds chip select high for at least four core clocks
// between frames so the frame words are read while they stand still.
`timescale 1ns/10ps
// Contract
// - Full erase ignored without write enable latch.
// - Select rise after erase opcode starts timed erase.
// - Busy during erase; latch cleared; busy cleared after.
// - Erase timeout clears latch, sets erase error.
// - Bad byte boundary: no erase, no flags, latch kept.
// - Any locked sector refuses full erase, sets flags one, five.
// - Program suspend sets bit two, then bit seven.
// - Erase suspend sets bit six, then bit seven.
// - Short remaining time completes, clears suspend flag.
// - Suspend state volatile; flags reset to 80h.
// - Erase suspend allows reads, programs elsewhere.
// - Program to suspended sector ignored, sets bit four.
// - Erase suspend accepts lock, configuration writes.
// - Program suspend allows reads, configuration writes.
// - One nesting level; resumes unwind in order.
// - Suspended within program or erase latency.
// - Suspend accepts reads; erase suspend most commands.
// - Standby rejects suspend; busy allows status, suspend.
// - Suspended states accept latch, flag, lock writes.
// - Resume sets busy, clears ready; ignored otherwise.
// - Write enable 06h, write disable 04h.
module flash_cmd_seq import flash_seq_pkg::*; #(
  parameter logic [8*op_count-1:0] op_table             = op_table_dflt,
  parameter int unsigned           full_array_erase_cycles = full_array_erase_cycles_dflt,
  parameter int unsigned           sector_erase_cycles  = sector_erase_cycles_dflt,
  parameter int unsigned           program_cycles       = program_cycles_dflt
) (
  // Core clock and reset
  input  wire logic    clock,
  input  wire logic    rst,
  // Serial link
  input  wire logic    sclk,
  input  wire logic    cs_n,
  input  wire logic    serial_io_line0,
  // Array conditions
  input  wire logic    any_sector_locked,
  input  wire logic    erase_timeout_fault,
  // Status
  output logic         write_in_progress,
  output logic         write_enable_latch,
  output logic [7:0]   flag_status,
  output report_t      report
);
  // ****************************************
  // Command table
  // ****************************************
  function automatic logic [7:0] op(input int unsigned i);
    op = op_table[8*(op_count-1-i) +: 8];
  endfunction : op

  function automatic bit table_ok();
    table_ok = (op(0) == op_write_enable_dflt) && (op(1) == op_write_disable_dflt);
    for (int i = 0; i < op_count; i++) begin
      for (int j = i + 1; j < op_count; j++) begin
        if (op(i) == op(j)) table_ok = 1'b0;
      end
    end
  endfunction : table_ok

  if (!table_ok()) begin : g_bad_table
    $error("Command codes must be distinct and keep the latch codes.");
  end
  if (full_array_erase_cycles < 2 || sector_erase_cycles < 2 || program_cycles < 2) begin : g_bad_t
    $error("Operation times must be at least two cycles.");
  end

  function automatic cls_t classify(input logic [7:0] c);
    classify = c_unknown;
    for (int i = 0; i < op_count; i++) begin
      if (c == op(i)) begin
        unique case (i)
          0, 1, 2, 3, 4, 5: classify = c_free_write;
          6, 7, 8, 11:      classify = c_guarded_write;
          9:                classify = c_full_erase;
          10:               classify = c_sector_erase;
          12:               classify = c_program;
          13:               classify = c_read;
          14, 15:           classify = c_status_read;
          16:               classify = c_suspend;
          default:          classify = c_resume;
        endcase
      end
    end
  endfunction : classify

  function automatic logic length_ok(input cls_t c, input bitcnt_t n);
    logic whole;
    whole = (n[2:0] == 3'h0) && (n >= bitcnt_t'(byte_bits));
    unique case (c)
      c_full_erase, c_suspend, c_resume: length_ok = (n == bitcnt_t'(byte_bits));
      c_sector_erase: length_ok = (n == bitcnt_t'(addr_end_bits));
      c_program:      length_ok = whole && (n >= bitcnt_t'(prog_min_bits));
      c_read:         length_ok = (n >= bitcnt_t'(addr_end_bits));
      c_status_read:  length_ok = (n >= bitcnt_t'(byte_bits));
      default:        length_ok = whole;
    endcase
  endfunction : length_ok

  function automatic logic allowed(input state_t s, input cls_t c, input logic hit);
    unique case (s)
      st_standby: allowed = !(c inside {c_suspend, c_resume, c_unknown});
      st_erase, st_prog, st_prog_es: allowed = c inside {c_status_read, c_suspend};
      st_esusp: allowed = (c inside {c_status_read, c_read, c_free_write, c_resume}) ||
                          (c == c_program && !hit);
      default: allowed = c inside {c_status_read, c_read, c_free_write, c_resume};
    endcase
  endfunction : allowed

  function automatic logic running(input state_t s);
    running = s inside {st_erase, st_prog, st_prog_es};
  endfunction : running

  // ****************************************
  // Link domain
  // ****************************************
  logic        first_reg;
  bitcnt_t     bitcnt_reg;
  logic [23:0] shift_reg;
  logic [7:0]  opcode_reg;
  logic [23:0] addr_reg;
  logic        link_idle;
  bitcnt_t     bit_next;

  assign link_idle = rst | cs_n;
  assign bit_next  = first_reg ? bitcnt_t'(1) : bitcnt_reg + bitcnt_t'(1);

  // The host clock stops between frames, so frame start is armed by select high.
  always_ff @(posedge sclk or posedge link_idle) begin
    if (link_idle) first_reg <= 1'b1;
    else first_reg <= 1'b0;
  end

  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      bitcnt_reg <= '0;
      shift_reg  <= '0;
      opcode_reg <= '0;
      addr_reg   <= '0;
    end else begin
      if (first_reg || bitcnt_reg != '1) bitcnt_reg <= bit_next;
      shift_reg <= {shift_reg[22:0], serial_io_line0};
      if (bit_next == bitcnt_t'(byte_bits)) opcode_reg <= {shift_reg[6:0], serial_io_line0};
      if (bit_next == bitcnt_t'(addr_end_bits)) addr_reg <= {shift_reg[22:0], serial_io_line0};
    end
  end

  // ****************************************
  // Frame capture in the core domain
  // ****************************************
  logic [2:0] cs_sync_reg;
  logic       frame_end;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) cs_sync_reg <= 3'h7;
    else cs_sync_reg <= {cs_sync_reg[1:0], cs_n};
  end
  // Frame words have stood still since the last serial edge when this fires.
  assign frame_end = cs_sync_reg[1] & ~cs_sync_reg[2];

  // ****************************************
  // Decode
  // ****************************************
  state_t      state_reg;
  state_t      state_next;
  logic        wel_reg;
  logic        wip_reg;
  logic [7:0]  fsr_reg;
  timer_t      erase_left_reg;
  timer_t      prog_left_reg;
  timer_t      susp_cnt_reg;
  logic        susp_pend_reg;
  logic        erase_whole_reg;
  logic [7:0]  erase_sector_reg;
  logic [15:0] prog_page_reg;
  cls_t        cls;
  logic        len_ok;
  logic        erase_hit;
  logic        page_hit;
  logic        exec;
  logic        start_erase;
  logic        erase_locked;
  logic        start_prog;
  logic        prog_blocked;
  logic        susp_req;
  logic        resume;
  logic        prog_run;
  logic        erase_run;
  logic        prog_fin;
  logic        erase_fin;
  logic        susp_fire;
  logic        frame_ok;

  assign cls       = classify(opcode_reg);
  assign len_ok    = length_ok(cls, bitcnt_reg);
  assign frame_ok  = frame_end && len_ok;
  assign erase_hit = (state_reg inside {st_esusp, st_prog_es, st_nested}) &&
                     (erase_whole_reg || addr_reg[23:sector_lsb] == erase_sector_reg);
  assign page_hit  = (state_reg inside {st_psusp, st_nested}) &&
                     (addr_reg[23:page_lsb] == prog_page_reg);
  assign exec      = frame_ok && allowed(state_reg, cls, erase_hit);
  assign start_erase  = exec && wel_reg && ((cls == c_full_erase && !any_sector_locked) ||
                        cls == c_sector_erase);
  assign erase_locked = exec && wel_reg && cls == c_full_erase && any_sector_locked;
  assign start_prog   = exec && wel_reg && cls == c_program;
  assign prog_blocked = frame_ok && cls == c_program && state_reg == st_esusp && erase_hit;
  // A suspend that lands on the last cycle of an operation is dropped, so the
  // operation simply completes and no stale suspend flag is left behind.
  assign susp_req     = exec && cls == c_suspend && !susp_pend_reg &&
                        !prog_fin && !erase_fin;
  assign resume       = exec && cls == c_resume;
  assign prog_run     = state_reg inside {st_prog, st_prog_es};
  assign erase_run    = state_reg == st_erase;
  assign prog_fin     = prog_run && prog_left_reg == timer_t'(1);
  assign erase_fin    = erase_run && (erase_left_reg == timer_t'(1) || erase_timeout_fault);
  // A latency that runs out after the operation ends never suspends it.
  assign susp_fire    = susp_pend_reg && susp_cnt_reg == timer_t'(1) &&
                        !prog_fin && !erase_fin;

  // ****************************************
  // State machine
  // ****************************************
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      st_standby: begin
        if (start_erase) state_next = st_erase;
        else if (start_prog) state_next = st_prog;
      end
      st_prog: begin
        if (prog_fin) state_next = st_standby;
        else if (susp_fire) state_next = st_psusp;
      end
      st_erase: begin
        if (erase_fin) state_next = st_standby;
        else if (susp_fire) state_next = st_esusp;
      end
      st_esusp: begin
        if (resume) state_next = st_erase;
        else if (start_prog) state_next = st_prog_es;
      end
      st_prog_es: begin
        if (prog_fin) state_next = st_esusp;
        else if (susp_fire) state_next = st_nested;
      end
      st_nested: if (resume) state_next = st_prog_es;
      st_psusp:  if (resume) state_next = st_prog;
      default:   state_next = st_standby;
    endcase
  end

  // Suspend context lives in these flops and the timer and flag flops, all loaded by rst, so any reset discards it.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) state_reg <= st_standby;
    else state_reg <= state_next;
  end

  // ****************************************
  // Operation timers
  // ****************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      erase_left_reg   <= '0;
      erase_whole_reg  <= 1'b0;
      erase_sector_reg <= '0;
    end else if (start_erase) begin
      erase_whole_reg  <= cls == c_full_erase;
      erase_sector_reg <= addr_reg[23:sector_lsb];
      erase_left_reg   <= timer_t'(cls == c_full_erase ? full_array_erase_cycles
                                                       : sector_erase_cycles);
    end else if (erase_run) begin
      erase_left_reg <= erase_left_reg - timer_t'(1);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prog_left_reg <= '0;
      prog_page_reg <= '0;
    end else if (start_prog) begin
      prog_left_reg <= timer_t'(program_cycles);
      prog_page_reg <= addr_reg[23:page_lsb];
    end else if (prog_run) begin
      prog_left_reg <= prog_left_reg - timer_t'(1);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      susp_pend_reg <= 1'b0;
      susp_cnt_reg  <= '0;
    end else if (susp_req) begin
      susp_pend_reg <= 1'b1;
      susp_cnt_reg  <= timer_t'(erase_run ? erase_latency_cycles
                                          : prog_latency_cycles);
    end else if (susp_pend_reg) begin
      susp_cnt_reg <= susp_cnt_reg - timer_t'(1);
      if (prog_fin || erase_fin || susp_fire) susp_pend_reg <= 1'b0;
    end
  end

  // ****************************************
  // Status bits
  // ****************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) wel_reg <= 1'b0;
    else if (exec && opcode_reg == op(0)) wel_reg <= 1'b1;
    else if (exec && opcode_reg == op(1)) wel_reg <= 1'b0;
    else if (start_erase || start_prog) wel_reg <= 1'b0;
    else if (erase_fin && erase_timeout_fault) wel_reg <= 1'b0;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) wip_reg <= 1'b0;
    else wip_reg <= running(state_next);
  end

  // Clears come first so that an error raised in the same cycle survives.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fsr_reg <= fsr_reset;
    end else begin
      if (exec && opcode_reg == op(2)) begin
        fsr_reg[fsr_erase_err] <= 1'b0;
        fsr_reg[fsr_prog_err]  <= 1'b0;
        fsr_reg[fsr_protect]   <= 1'b0;
      end
      fsr_reg[fsr_ready] <= !running(state_next);
      if (prog_fin && susp_pend_reg) fsr_reg[fsr_prog_susp] <= 1'b0;
      if (erase_fin && susp_pend_reg) fsr_reg[fsr_erase_susp] <= 1'b0;
      if (resume && state_reg != st_esusp) fsr_reg[fsr_prog_susp] <= 1'b0;
      if (resume && state_reg == st_esusp) fsr_reg[fsr_erase_susp] <= 1'b0;
      if (susp_req && prog_run) fsr_reg[fsr_prog_susp] <= 1'b1;
      if (susp_req && erase_run) fsr_reg[fsr_erase_susp] <= 1'b1;
      if (erase_fin && erase_timeout_fault) fsr_reg[fsr_erase_err] <= 1'b1;
      if (prog_blocked) fsr_reg[fsr_prog_err] <= 1'b1;
      if (erase_locked) begin
        fsr_reg[fsr_protect]   <= 1'b1;
        fsr_reg[fsr_erase_err] <= 1'b1;
      end
    end
  end

  // ****************************************
  // Command report
  // ****************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      report <= '0;
    end else begin
      report.done           <= frame_ok;
      report.accepted       <= exec;
      report.undefined_read <= exec && cls == c_read && (erase_hit || page_hit);
      report.opcode         <= opcode_reg;
      report.addr           <= addr_reg;
    end
  end

  assign write_in_progress  = wip_reg;
  assign write_enable_latch = wel_reg;
  assign flag_status        = fsr_reg;

  // ****************************************
  // Checks
  // ****************************************
  property p_erase_needs_wel;
    @(posedge clock) disable iff (rst)
    frame_ok && cls == c_full_erase && !wel_reg |=> state_reg == $past(state_reg) && !wel_reg;
  endproperty
  a_erase_needs_wel: assert property (p_erase_needs_wel) else $error("Erase ran without latch.");

  property p_erase_start;
    @(posedge clock) disable iff (rst)
    start_erase |=> wip_reg && !wel_reg && !fsr_reg[fsr_ready] && state_reg == st_erase;
  endproperty
  a_erase_start: assert property (p_erase_start) else $error("Erase start wrong.");

  property p_timeout;
    @(posedge clock) disable iff (rst)
    erase_run && erase_timeout_fault |=> fsr_reg[fsr_erase_err] && !wel_reg && !wip_reg;
  endproperty
  a_timeout: assert property (p_timeout) else $error("Timeout handling wrong.");

  property p_bad_boundary;
    @(posedge clock) disable iff (rst)
    frame_end && !len_ok |=> state_reg == $past(state_reg) && wel_reg == $past(wel_reg);
  endproperty
  a_bad_boundary: assert property (p_bad_boundary) else $error("Torn frame acted.");

  property p_locked;
    @(posedge clock) disable iff (rst)
    erase_locked |=> wel_reg && fsr_reg[fsr_protect] && fsr_reg[fsr_erase_err] &&
                     state_reg == st_standby;
  endproperty
  a_locked: assert property (p_locked) else $error("Locked erase not refused.");

  property p_prog_suspend;
    @(posedge clock) disable iff (rst)
    susp_req && prog_run && prog_left_reg > timer_t'(2) |=>
                             fsr_reg[fsr_prog_susp] && !fsr_reg[fsr_ready] ##1
                             !fsr_reg[fsr_ready];
  endproperty
  a_prog_suspend: assert property (p_prog_suspend) else $error("Program suspend wrong.");

  property p_susp_enter;
    @(posedge clock) disable iff (rst)
    susp_fire |=> fsr_reg[fsr_ready] && !wip_reg && state_reg inside {st_psusp, st_esusp, st_nested};
  endproperty
  a_susp_enter: assert property (p_susp_enter) else $error("Suspend entry wrong.");

  property p_short_finish;
    @(posedge clock) disable iff (rst)
    susp_pend_reg && erase_fin |=> !fsr_reg[fsr_erase_susp] && state_reg == st_standby;
  endproperty
  a_short_finish: assert property (p_short_finish) else $error("Late suspend kept.");

  property p_blocked_prog;
    @(posedge clock) disable iff (rst)
    prog_blocked |=> fsr_reg[fsr_prog_err] && wel_reg == $past(wel_reg) && state_reg == st_esusp;
  endproperty
  a_blocked_prog: assert property (p_blocked_prog) else $error("Program hit suspended erase.");

  property p_resume;
    @(posedge clock) disable iff (rst)
    resume |=> wip_reg && !fsr_reg[fsr_ready];
  endproperty
  a_resume: assert property (p_resume) else $error("Resume did not restart.");

  property p_resume_idle;
    @(posedge clock) disable iff (rst)
    frame_ok && cls == c_resume && state_reg == st_standby |=> !wip_reg && !report.accepted;
  endproperty
  a_resume_idle: assert property (p_resume_idle) else $error("Idle resume acted.");
endmodule : flash_cmd_seq

// ---- testbench/spi_host_model.sv ----
// Host model that shifts command frames into the flash sequencer, SPI mode 0.
// Assumes the bench calls send_frame and leaves chip select idle in between.
`timescale 1ns/10ps
module spi_host_model (
  // Serial link
  output logic sclk,
  output logic cs_n,
  output logic serial_io_line0
);
  initial begin
    sclk            = 1'b0;
    cs_n            = 1'b1;
    serial_io_line0 = 1'b0;
  end
  // The link clock stands still between frames; the idle data line flips so
  // that a design that samples outside a frame sees a wrong bit.
  task automatic send_frame(input logic [39:0] bits, input int n);
    int i;
    cs_n = 1'b0;
    for (i = 0; i < n; i++) begin
      serial_io_line0 = bits[39-i];
      #6 sclk = 1'b1;
      #6 sclk = 1'b0;
    end
    #3 cs_n = 1'b1;
    serial_io_line0 = ~serial_io_line0;
    #40;
  endtask : send_frame
endmodule : spi_host_model

// ---- testbench/bulk_erase_suspend_resume_ctrl_tb_top.sv ----
// Self-checking bench for the flash command sequencer.
// Assumes short erase and program counts so that suspends can be reached.
`timescale 1ns/10ps
module bulk_erase_suspend_resume_ctrl_tb_top import flash_seq_pkg::*;;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        sclk, cs_n, sio;
  logic        locked = 1'b0;
  logic        fault = 1'b0;
  logic        wip, wel;
  logic [7:0]  fsr;
  report_t     rep;
  logic        got_done;
  logic        got_acc;
  logic        got_und;
  int          mismatches = 0;
  int          checks = 0;
  always #2 clock = ~clock;
  spi_host_model host (.sclk(sclk), .cs_n(cs_n), .serial_io_line0(sio));
  flash_cmd_seq #(.full_array_erase_cycles(200), .sector_erase_cycles(5000),
    .program_cycles(3000)) DUT (.clock(clock), .rst(rst), .sclk(sclk), .cs_n(cs_n),
    .serial_io_line0(sio), .any_sector_locked(locked), .erase_timeout_fault(fault),
    .write_in_progress(wip), .write_enable_latch(wel), .flag_status(fsr), .report(rep));
  always @(posedge clock) if (rep.done === 1'b1) begin
    got_done = 1'b1;
    got_acc  = rep.accepted;
    got_und  = rep.undefined_read;
  end
  task automatic stop_test();
    if (mismatches == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Sends one frame, checks whether a report came, then the status word.
  task automatic cmd(input logic [7:0] op, input logic [31:0] rest, input int n,
                     input logic done_exp, input logic [9:0] st_exp);
    got_done = 1'b0;
    host.send_frame({op, rest}, n);
    @(posedge clock);
    #1;
    check({9'h0, got_done}, {9'h0, done_exp});
    check({wip, wel, fsr}, st_exp);
  endtask : cmd
  // Waiting is bounded; running out of cycles ends the run as a failure.
  task automatic idle(input int lim, input logic [9:0] st_exp);
    int i;
    for (i = 0; i < lim && wip !== 1'b0; i++) @(posedge clock);
    #1;
    if (wip !== 1'b0) begin
      mismatches++;
      $display("[ERR] %0t busy wait ran out", $time);
      stop_test();
    end
    check({wip, wel, fsr}, st_exp);
  endtask : idle
  initial begin
    repeat (12) @(posedge clock);
    #1 rst = 1'b0;
    check({wip, wel, fsr}, 10'h080);
    cmd(8'hc7, 32'h0, 8, 1'b1, 10'h080);
    cmd(8'h06, 32'h0, 8, 1'b1, 10'h180);
    cmd(8'hc7, 32'h0, 7, 1'b0, 10'h180);
    locked = 1'b1;
    cmd(8'hc7, 32'h0, 8, 1'b1, 10'h1a2);
    locked = 1'b0;
    cmd(8'h50, 32'h0, 8, 1'b1, 10'h180);
    cmd(8'hc7, 32'h0, 8, 1'b1, 10'h200);
    idle(300, 10'h080);
    cmd(8'h06, 32'h0, 8, 1'b1, 10'h180);
    cmd(8'hc7, 32'h0, 8, 1'b1, 10'h200);
    @(posedge clock) #1 fault = 1'b1;
    idle(20, 10'h0a0);
    fault = 1'b0;
    cmd(8'h50, 32'h0, 8, 1'b1, 10'h080);
    cmd(8'h75, 32'h0, 8, 1'b1, 10'h080);
    check({8'h0, got_acc, got_und}, 10'h000);
    cmd(8'h06, 32'h0, 8, 1'b1, 10'h180);
    cmd(8'hd8, 32'h03000000, 32, 1'b1, 10'h200);
    cmd(8'h75, 32'h0, 8, 1'b1, 10'h240);
    idle(4000, 10'h0c0);
    cmd(8'hc7, 32'h0, 8, 1'b1, 10'h0c0);
    check({8'h0, got_acc, got_und}, 10'h000);
    cmd(8'he5, 32'h0, 16, 1'b1, 10'h0c0);
    check({8'h0, got_acc, got_und}, 10'h002);
    cmd(8'h03, 32'h03000000, 32, 1'b1, 10'h0c0);
    check({8'h0, got_acc, got_und}, 10'h003);
    check({2'h0, rep.addr[23:16]}, 10'h003);
    cmd(8'h06, 32'h0, 8, 1'b1, 10'h1c0);
    cmd(8'h02, 32'h030000a5, 40, 1'b1, 10'h1d0);
    check({8'h0, got_acc, got_und}, 10'h000);
    cmd(8'h50, 32'h0, 8, 1'b1, 10'h1c0);
    cmd(8'h02, 32'h050000a5, 40, 1'b1, 10'h240);
    check({2'h0, rep.opcode}, 10'h002);
    cmd(8'h75, 32'h0, 8, 1'b1, 10'h244);
    idle(2000, 10'h0c4);
    cmd(8'h03, 32'h05000000, 32, 1'b1, 10'h0c4);
    check({8'h0, got_acc, got_und}, 10'h003);
    cmd(8'h7a, 32'h0, 8, 1'b1, 10'h240);
    idle(3000, 10'h0c0);
    locked = 1'b1;
    cmd(8'h7a, 32'h0, 8, 1'b1, 10'h200);
    locked = 1'b0;
    idle(6000, 10'h080);
    cmd(8'h06, 32'h0, 8, 1'b1, 10'h180);
    cmd(8'hc7, 32'h0, 8, 1'b1, 10'h200);
    cmd(8'h75, 32'h0, 8, 1'b1, 10'h240);
    idle(300, 10'h080);
    cmd(8'h7a, 32'h0, 8, 1'b1, 10'h080);
    check({8'h0, got_acc, got_und}, 10'h000);
    cmd(8'h06, 32'h0, 8, 1'b1, 10'h180);
    cmd(8'hd8, 32'h03000000, 32, 1'b1, 10'h200);
    cmd(8'h75, 32'h0, 8, 1'b1, 10'h240);
    idle(4000, 10'h0c0);
    @(posedge clock);
    #1 rst = 1'b1;
    repeat (2) @(posedge clock);
    #1 rst = 1'b0;
    check({wip, wel, fsr}, 10'h080);
    cmd(8'h7a, 32'h0, 8, 1'b1, 10'h080);
    stop_test();
  end
endmodule : bulk_erase_suspend_resume_ctrl_tb_top
